// ==== verilog/dpr_pkg.sv ====
package dpr_pkg;
  localparam int unsigned DPR_ADDR_W = 16;
  localparam int unsigned DPR_DATA_W = 16;
  localparam int unsigned DPR_BYTE_W = 8;
  localparam logic [DPR_BYTE_W-1:0] DPR_ZERO_BYTE = 8'h00;
  localparam int unsigned DPR_BYTES = 2048;
  localparam int unsigned DPR_WORDS = DPR_BYTES / 2;
  localparam int unsigned DPR_IDX_W = $clog2(DPR_WORDS);
  // Top of the 32 Kbyte implemented half of data space
  localparam logic [DPR_ADDR_W-1:0] DPR_BASE_DEF = 16'h7800;
  localparam logic [DPR_DATA_W-1:0] DPR_ZERO = 16'h0000;
  localparam int unsigned DPR_LANE_BIT = 0;

  typedef struct packed {
    logic en;
    logic we;
    logic byte_op;
    logic [DPR_ADDR_W-1:0] addr;
    logic [DPR_DATA_W-1:0] wdata;
  } dpr_req_t;
endpackage : dpr_pkg

// ==== verilog/dpr_dual_port_ram.sv ====
`timescale 1ns/1ps
module dpr_dual_port_ram
  import dpr_pkg::*;
#(
  parameter logic [DPR_ADDR_W-1:0] BASE = DPR_BASE_DEF,
  parameter int unsigned WORDS = DPR_WORDS
)(
  input wire logic core_clk,
  input wire logic reset,
  input wire dpr_req_t cpu_req,
  output logic [DPR_DATA_W-1:0] cpu_rdata,
  output logic cpu_hit,
  input wire dpr_req_t dma_req,
  output logic [DPR_DATA_W-1:0] dma_rdata,
  output logic dma_hit
);
  localparam int unsigned IW = $clog2(WORDS);
  localparam logic [DPR_ADDR_W-1:0] SPAN = DPR_ADDR_W'(2 * WORDS);

  typedef struct packed {
    logic [WORDS-1:0][DPR_DATA_W-1:0] mem;
    logic [DPR_DATA_W-1:0] cpu_rd;
    logic [DPR_DATA_W-1:0] dma_rd;
    logic cpu_hit;
    logic dma_hit;
  } dpr_state_t;

  dpr_state_t st_q;
  dpr_state_t st_d;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  function automatic logic in_window(input logic [DPR_ADDR_W-1:0] a);
    in_window = (a >= BASE) && ((a - BASE) < SPAN);
  endfunction : in_window

  function automatic logic [IW-1:0] word_idx(input logic [DPR_ADDR_W-1:0] a);
    logic [DPR_ADDR_W-1:0] off;
    off = a - BASE;
    word_idx = off[IW:1];
  endfunction : word_idx

  function automatic logic hi_lane(input dpr_req_t r);
    hi_lane = r.addr[DPR_LANE_BIT];
  endfunction : hi_lane

  function automatic logic [DPR_BYTE_W-1:0] lane_of(input logic [DPR_DATA_W-1:0] w,
                                                    input logic hi);
    lane_of = hi ? w[DPR_DATA_W-1:DPR_BYTE_W] : w[DPR_BYTE_W-1:0];
  endfunction : lane_of

  // lane mask, byte data taken from low byte
  function automatic logic [DPR_DATA_W-1:0] merge(input logic [DPR_DATA_W-1:0] old,
                                                 input dpr_req_t r);
    merge = old;
    if (!r.byte_op)
    begin
      merge = r.wdata;
    end
    else if (hi_lane(r))
    begin
      merge[DPR_DATA_W-1:DPR_BYTE_W] = r.wdata[DPR_BYTE_W-1:0];
    end
    else
    begin
      merge[DPR_BYTE_W-1:0] = r.wdata[DPR_BYTE_W-1:0];
    end
  endfunction : merge

  // Byte reads land in the low byte, word reads whole
  function automatic logic [DPR_DATA_W-1:0] pick(input logic [DPR_DATA_W-1:0] w,
                                                input dpr_req_t r);
    pick = w;
    if (r.byte_op)
    begin
      pick = {DPR_ZERO_BYTE, lane_of(w, hi_lane(r))};
    end
  endfunction : pick

  logic cpu_sel;
  logic dma_sel;
  logic [IW-1:0] cpu_i;
  logic [IW-1:0] dma_i;

  always_comb
  begin
    cpu_sel = cpu_req.en && in_window(cpu_req.addr);
    dma_sel = dma_req.en && in_window(dma_req.addr);
    cpu_i = word_idx(cpu_req.addr);
    dma_i = word_idx(dma_req.addr);
    st_d = st_q;
    st_d.cpu_hit = cpu_sel;
    st_d.dma_hit = dma_sel;
    // no arbitration path back to the processor
    st_d.cpu_rd = cpu_sel ? pick(st_q.mem[cpu_i], cpu_req) : DPR_ZERO;
    st_d.dma_rd = dma_sel ? pick(st_q.mem[dma_i], dma_req) : DPR_ZERO;
    // controller write applied first; a processor write to the same word then overwrites the lanes it writes
    if (dma_sel && dma_req.we)
    begin
      st_d.mem[dma_i] = merge(st_q.mem[dma_i], dma_req);
    end
    // processor write last so it wins; plain storage
    if (cpu_sel && cpu_req.we)
    begin
      st_d.mem[cpu_i] = merge(st_d.mem[cpu_i], cpu_req);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cpu_rdata = st_q.cpu_rd;
  assign dma_rdata = st_q.dma_rd;
  assign cpu_hit = st_q.cpu_hit;
  assign dma_hit = st_q.dma_hit;

  logic cw;
  logic dw;
  assign cw = cpu_sel && cpu_req.we;
  assign dw = dma_sel && dma_req.we;

  cpu_wins_a: assert property (
    cw && dw && !cpu_req.byte_op && cpu_i == dma_i |=> st_q.mem[$past(cpu_i)] == $past(cpu_req.wdata))
    else $error("processor write lost in collision");

  dma_drop_a: assert property (
    cw && dw && !cpu_req.byte_op && cpu_i == dma_i && cpu_req.wdata != dma_req.wdata
    |=> st_q.mem[$past(cpu_i)] != $past(dma_req.wdata))
    else $error("controller write not dropped");

  word_write_a: assert property (
    cw && !cpu_req.byte_op && !(dw && dma_i == cpu_i) |=> st_q.mem[$past(cpu_i)] == $past(cpu_req.wdata))
    else $error("word write not stored");

  dma_write_a: assert property (
    dw && !dma_req.byte_op && !(cw && cpu_i == dma_i) |=> st_q.mem[$past(dma_i)] == $past(dma_req.wdata))
    else $error("controller write not stored");

  byte_lane_a: assert property (
    cw && cpu_req.byte_op && !(dw && dma_i == cpu_i)
    |=> lane_of(st_q.mem[$past(cpu_i)], !$past(hi_lane(cpu_req)))
        == $past(lane_of(st_q.mem[cpu_i], !hi_lane(cpu_req))))
    else $error("byte write touched other lane");

  dma_lane_a: assert property (
    dw && dma_req.byte_op && !(cw && cpu_i == dma_i)
    |=> lane_of(st_q.mem[$past(dma_i)], !$past(hi_lane(dma_req)))
        == $past(lane_of(st_q.mem[dma_i], !hi_lane(dma_req))))
    else $error("controller byte write touched other lane");

  cpu_read_a: assert property (
    cpu_sel && !cpu_req.byte_op |=> cpu_hit && cpu_rdata == $past(st_q.mem[cpu_i]))
    else $error("processor read wrong or stalled");

  cpu_hit_a: assert property (
    1'b1 |=> cpu_hit == $past(cpu_sel))
    else $error("processor answer missing or late");

  dma_read_a: assert property (
    dma_sel && !dma_req.byte_op |=> dma_hit && dma_rdata == $past(st_q.mem[dma_i]))
    else $error("controller read wrong");

  dma_hit_a: assert property (
    1'b1 |=> dma_hit == $past(dma_sel))
    else $error("controller answer missing or late");

  cpu_rd_hi_a: assert property (
    cpu_sel && cpu_req.byte_op && hi_lane(cpu_req)
    |=> cpu_rdata == {DPR_ZERO_BYTE, $past(st_q.mem[cpu_i][DPR_DATA_W-1:DPR_BYTE_W])})
    else $error("processor high byte read wrong");

  cpu_rd_lo_a: assert property (
    cpu_sel && cpu_req.byte_op && !hi_lane(cpu_req)
    |=> cpu_rdata == {DPR_ZERO_BYTE, $past(st_q.mem[cpu_i][DPR_BYTE_W-1:0])})
    else $error("processor low byte read wrong");

  dma_rd_hi_a: assert property (
    dma_sel && dma_req.byte_op && hi_lane(dma_req)
    |=> dma_rdata == {DPR_ZERO_BYTE, $past(st_q.mem[dma_i][DPR_DATA_W-1:DPR_BYTE_W])})
    else $error("controller high byte read wrong");

  dma_rd_lo_a: assert property (
    dma_sel && dma_req.byte_op && !hi_lane(dma_req)
    |=> dma_rdata == {DPR_ZERO_BYTE, $past(st_q.mem[dma_i][DPR_BYTE_W-1:0])})
    else $error("controller low byte read wrong");

  window_a: assert property (
    cpu_req.en && !in_window(cpu_req.addr) |=> !cpu_hit && cpu_rdata == DPR_ZERO)
    else $error("access outside window decoded");

  dma_window_a: assert property (
    dma_req.en && !in_window(dma_req.addr) |=> !dma_hit && dma_rdata == DPR_ZERO)
    else $error("controller access outside window decoded");

  cpu_idle_a: assert property (
    !cpu_req.en |=> !cpu_hit && cpu_rdata == DPR_ZERO)
    else $error("processor answer without access");

  dma_idle_a: assert property (
    !dma_req.en |=> !dma_hit && dma_rdata == DPR_ZERO)
    else $error("controller answer without access");

  mem_hold_a: assert property (
    !cw && !dw |=> $stable(st_q.mem))
    else $error("memory changed without a write");

  collide_c: cover property (cw && dw && cpu_i == dma_i);
  both_c: cover property (cpu_sel && dma_sel && cpu_i != dma_i);
  byte_c: cover property (cw && cpu_req.byte_op ##1 cpu_sel);
  dma_byte_c: cover property (dw && dma_req.byte_op);
  miss_c: cover property (cpu_req.en && !cpu_sel);
endmodule : dpr_dual_port_ram

// ==== test/dpr_dma_model.sv ====
`timescale 1ns/1ps
module dpr_dma_model
  import dpr_pkg::*;
(
  input wire dpr_req_t cmd,
  output dpr_req_t dma_req
);
  // Idle bus shows inverted bits, never stale values
  assign dma_req = cmd.en ? cmd : {1'b0, ~cmd[33:0]};
endmodule : dpr_dma_model

// ==== test/test_dual_port_dma_ram.sv ====
`timescale 1ns/1ps
module test_dual_port_dma_ram
  import dpr_pkg::*;
;
  logic core_clk = 0;
  logic reset = 1;
  dpr_req_t cpu_req = '0, dma_cmd = '0, dma_req;
  logic [15:0] cpu_rdata, dma_rdata;
  logic cpu_hit, dma_hit;
  logic [15:0] mem [DPR_WORDS] = '{default: 16'h0000};
  logic [17:0] qc[$], qd[$];
  int num_errors = 0, tests_run = 0;
  logic [31:0] seed = 32'h6bd7f145;
  always #12.5 core_clk = ~core_clk;
  dpr_dual_port_ram u_dpr_dual_port_ram (.core_clk(core_clk), .reset(reset), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit), .dma_req(dma_req), .dma_rdata(dma_rdata), .dma_hit(dma_hit));
  dpr_dma_model u_dpr_dma_model (.cmd(dma_cmd), .dma_req(dma_req));
  function automatic logic in_win(dpr_req_t r);
    return r.en && r.addr >= DPR_BASE_DEF && r.addr < DPR_BASE_DEF + 2 * DPR_WORDS;
  endfunction : in_win
  // Write results carry the old word, but their read data is not compared
  function automatic logic [17:0] expect_of(dpr_req_t r);
    logic [15:0] w;
    w = mem[r.addr[DPR_IDX_W:1]];
    if (!in_win(r))
      return 18'h20000;
    if (r.byte_op)
      w = r.addr[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    return {!r.we, 1'b1, w};
  endfunction : expect_of
  task automatic put(dpr_req_t r);
    if (in_win(r) && r.we && (!r.byte_op || !r.addr[0]))
      mem[r.addr[DPR_IDX_W:1]][7:0] = r.wdata[7:0];
    if (in_win(r) && r.we && (!r.byte_op || r.addr[0]))
      mem[r.addr[DPR_IDX_W:1]][15:8] = r.wdata[15:8];
  endtask : put
  task automatic step(dpr_req_t c, dpr_req_t d);
    qc.push_back(expect_of(c));
    qd.push_back(expect_of(d));
    put(d);
    put(c);
    cpu_req <= c;
    dma_cmd <= d;
    @(posedge core_clk);
  endtask : step
  function automatic dpr_req_t rnd(logic [15:0] base, logic [15:0] mask, logic on);
    dpr_req_t r;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    r.en = on & (seed[0] | seed[3]);
    r.we = seed[1];
    r.byte_op = seed[2];
    r.addr = base + (seed[31:16] & mask);
    r.addr[0] = r.addr[0] & r.byte_op;
    r.wdata = r.byte_op ? {2{seed[15:8]}} : seed[15:0];
    return r;
  endfunction : rnd
  task automatic run(logic [15:0] base, logic [15:0] mask, logic on, string name);
    repeat (400) step(rnd(base, mask, 1'b1), rnd(base, mask, on));
    $display("%s done", name);
  endtask : run
  task automatic chk(logic h, logic [15:0] d, logic [17:0] e);
    tests_run++;
    if (h !== e[16] || (e[17] && d !== e[15:0]))
      begin
      num_errors++;
      $display("BAD %0t port result mismatch", $time);
      end
  endtask : chk
  always @(negedge core_clk)
    if (qc.size() > 1)
      begin
      chk(cpu_hit, cpu_rdata, qc.pop_front());
      chk(dma_hit, dma_rdata, qd.pop_front());
      end
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial
    begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    run(16'h7800, 16'h001F, 1'b1, "collide");
    run(16'h7600, 16'h0FFF, 1'b1, "window");
    run(16'h7800, 16'h07FF, 1'b0, "cpu only");
    step('0, '0);
    step('0, '0);
    end_of_test();
    end
  initial
    begin
    #60000;
    num_errors++;
    end_of_test();
    end
endmodule : test_dual_port_dma_ram
